/* rtl/audio_port_map.vh */
// register map, field positions and reset values of the audio serial port
`ifndef AUDIO_PORT_MAP_VH
`define AUDIO_PORT_MAP_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_SERIAL_PORT_FORMAT_CONTROL 4'h4
`define IDX_COMPANDER_WORD_CONTROL 4'h5
`define IDX_CLOCK_GENERATION_CONTROL 4'h6
`define IDX_ADDITIONAL_RATE_CONTROL 4'h7
`define IDX_PORT_STATUS 4'h8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_SERIAL_PORT_FORMAT_CONTROL 10'h050
`define RST_COMPANDER_WORD_CONTROL 10'h000
`define RST_CLOCK_GENERATION_CONTROL 10'h140
`define RST_ADDITIONAL_RATE_CONTROL 10'h000

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MONO_DUPLICATE_BOTH_SLOTS_BIT 9
`define BIT_CLOCK_INVERT_BIT 8
`define FRAME_POLARITY_OR_DSP_OFFSET_BIT 7
`define WORD_SIZE_FIELD_HI 6
`define WORD_SIZE_FIELD_LO 5
`define FRAMING_SELECT_HI 4
`define FRAMING_SELECT_LO 3
`define PLAYBACK_PHASE_SWAP_BIT 2
`define CAPTURE_PHASE_SWAP_BIT 1
`define BYTE_WORD_ENABLE_BIT 5
`define SYSTEM_CLOCK_SOURCE_BIT 8
`define SYSTEM_CLOCK_DIVIDER_HI 7
`define SYSTEM_CLOCK_DIVIDER_LO 5
`define BIT_CLOCK_DIVIDER_HI 4
`define BIT_CLOCK_DIVIDER_LO 2
`define PORT_MASTER_SELECT_BIT 0
`define SAMPLE_RATE_CODE_HI 3
`define SAMPLE_RATE_CODE_LO 1

// ----------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------
`define FMT_RIGHT_JUSTIFIED 2'b00
`define FMT_LEFT_JUSTIFIED 2'b01
`define FMT_I2S 2'b10
`define FMT_DSP 2'b11
`define BIT_CLOCK_DIVIDER_MAX 3'h5
`define SAMPLE_RATE_CODE_MAX 3'h5
`define MASTER_HALF_FRAME_BITS 6'h20
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

/* rtl/audio_clock_gen.v */
// system clock tick divider and master bit clock generator
`timescale 1ns/100ps
`default_nettype none
`include "audio_port_map.vh"

module audio_clock_gen (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // source tick and settings
  input wire base_tick,
  input wire [2:0] sys_div_code,
  input wire [2:0] bclk_div_code,
  input wire run,
  // generated ticks and bit clock
  output reg sys_tick_reg,
  output reg bclk_reg,
  output reg bclk_rise_reg,
  output reg bclk_fall_reg
);

  // ----------------------------------------------------------------------
  // divider tables
  // ----------------------------------------------------------------------
  // divisor in half units so that divide by 1.5 and 3 need no second clock
  function [4:0] half_div;
    input [2:0] code;
    begin
      case (code)
        3'h0: half_div = 5'h02;
        3'h1: half_div = 5'h03;
        3'h2: half_div = 5'h04;
        3'h3: half_div = 5'h06;
        3'h4: half_div = 5'h08;
        3'h5: half_div = 5'h0c;
        3'h6: half_div = 5'h10;
        default: half_div = 5'h18;
      endcase
    end
  endfunction

  reg [4:0] acc_reg;
  reg [5:0] bcnt_reg;
  wire [4:0] acc_sum = acc_reg + 5'h02;
  wire [4:0] div2 = half_div(sys_div_code);
  // reserved divider codes behave as the slowest legal one
  wire [2:0] bcode = (bclk_div_code > `BIT_CLOCK_DIVIDER_MAX) ?
                     `BIT_CLOCK_DIVIDER_MAX : bclk_div_code;
  wire [5:0] bhalf = 6'h01 << bcode;

  // ----------------------------------------------------------------------
  // fractional system clock divider
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= 5'h00;
      sys_tick_reg <= 1'b0;
    end else begin
      sys_tick_reg <= 1'b0;
      if (base_tick) begin
        if (acc_sum >= div2) begin
          acc_reg <= acc_sum - div2;
          sys_tick_reg <= 1'b1;
        end else begin
          acc_reg <= acc_sum;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // bit clock, toggled every 2^code system ticks
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      bcnt_reg <= 6'h00;
      bclk_reg <= 1'b1;
      bclk_rise_reg <= 1'b0;
      bclk_fall_reg <= 1'b0;
    end else begin
      bclk_rise_reg <= 1'b0;
      bclk_fall_reg <= 1'b0;
      if (!run) begin
        bcnt_reg <= 6'h00;
        bclk_reg <= 1'b1;
      end else if (sys_tick_reg) begin
        if (bcnt_reg + 6'h01 >= bhalf) begin
          bcnt_reg <= 6'h00;
          bclk_reg <= ~bclk_reg;
          bclk_rise_reg <= ~bclk_reg;
          bclk_fall_reg <= bclk_reg;
        end else begin
          bcnt_reg <= bcnt_reg + 6'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/mono_codec_audio_port_ctrl.v */
// audio serial port control: registers, clocking, framing and shifting
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "audio_port_map.vh"

module mono_codec_audio_port_ctrl (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write channels
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read channels
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // clock sources
  input wire mclk_pin,
  input wire pll_tick,
  // bit clock pin
  input wire bclk_in,
  output reg bclk_out,
  output reg bclk_oe_n,
  // frame clock pin
  input wire frame_in,
  output reg frame_out,
  output reg frame_oe_n,
  // serial data pins
  input wire playback_serial_in,
  output reg capture_serial_out,
  // converter side
  input wire [31:0] capture_word,
  output reg [31:0] playback_word,
  output reg playback_strobe,
  output wire sys_clk_tick,
  output reg [2:0] filter_rate_sel
);

  // ----------------------------------------------------------------------
  // registers and fields
  // ----------------------------------------------------------------------
  reg [9:0] fmt_ctl_reg;
  reg [9:0] cmp_ctl_reg;
  reg [9:0] clk_ctl_reg;
  reg [9:0] rate_ctl_reg;

  wire mono_dup = fmt_ctl_reg[`MONO_DUPLICATE_BOTH_SLOTS_BIT];
  wire bclk_inv = fmt_ctl_reg[`BIT_CLOCK_INVERT_BIT];
  wire fpol = fmt_ctl_reg[`FRAME_POLARITY_OR_DSP_OFFSET_BIT];
  wire [1:0] wl_code = fmt_ctl_reg[`WORD_SIZE_FIELD_HI:`WORD_SIZE_FIELD_LO];
  wire [1:0] fmt = fmt_ctl_reg[`FRAMING_SELECT_HI:`FRAMING_SELECT_LO];
  wire play_swap = fmt_ctl_reg[`PLAYBACK_PHASE_SWAP_BIT];
  wire cap_swap = fmt_ctl_reg[`CAPTURE_PHASE_SWAP_BIT];
  wire byte_en = cmp_ctl_reg[`BYTE_WORD_ENABLE_BIT];
  wire clk_src = clk_ctl_reg[`SYSTEM_CLOCK_SOURCE_BIT];
  wire [2:0] sys_div = clk_ctl_reg[`SYSTEM_CLOCK_DIVIDER_HI:`SYSTEM_CLOCK_DIVIDER_LO];
  wire [2:0] bclk_div = clk_ctl_reg[`BIT_CLOCK_DIVIDER_HI:`BIT_CLOCK_DIVIDER_LO];
  wire master = clk_ctl_reg[`PORT_MASTER_SELECT_BIT];
  wire [2:0] rate_code = rate_ctl_reg[`SAMPLE_RATE_CODE_HI:`SAMPLE_RATE_CODE_LO];
  wire dsp = (fmt == `FMT_DSP);
  // left phase is frame high except for I2S, where it is frame low
  wire left_lvl = (fmt != `FMT_I2S);

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // effective serial word length in bits
  function [5:0] word_bits;
    input [1:0] code;
    input [1:0] form;
    input b8;
    begin
      if (b8) begin
        word_bits = 6'd8;
      end else begin
        case (code)
          2'b00: word_bits = 6'd16;
          2'b01: word_bits = 6'd20;
          2'b10: word_bits = 6'd24;
          default: word_bits = (form == `FMT_RIGHT_JUSTIFIED) ? 6'd24 : 6'd32;
        endcase
      end
    end
  endfunction

  // slot lookup for a bit position: {valid, slot, index}
  function [7:0] slot_of;
    input [6:0] p;
    input [6:0] off;
    input [6:0] wl;
    input is_dsp;
    input phase;
    reg [6:0] rel;
    begin
      rel = p - off;
      slot_of = 8'h00;
      if (p >= off) begin
        if (rel < wl) begin
          slot_of = {1'b1, (is_dsp ? 1'b0 : phase), rel[5:0]};
        end else if (is_dsp && (rel < (wl + wl))) begin
          rel = rel - wl;
          slot_of = {1'b1, 1'b1, rel[5:0]};
        end
      end
    end
  endfunction

  // byte-lane merge for a 10-bit register
  function [9:0] merge;
    input [9:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge = {(strb[1] ? data[9:8] : old[9:8]), (strb[0] ? data[7:0] : old[7:0])};
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  reg [2:0] mclk_s;
  reg [2:0] bclk_s;
  reg [1:0] frame_s;
  reg [1:0] din_s;
  // stage 2 is the first stage any logic reads; stage 3 is only its past value
  always @(posedge aclk) begin
    if (!aresetn) begin
      mclk_s <= 3'b000;
      bclk_s <= 3'b000;
      frame_s <= 2'b00;
      din_s <= 2'b00;
    end else begin
      mclk_s <= {mclk_s[1:0], mclk_pin};
      bclk_s <= {bclk_s[1:0], bclk_in};
      frame_s <= {frame_s[0], frame_in};
      din_s <= {din_s[0], playback_serial_in};
    end
  end

  // ----------------------------------------------------------------------
  // clock generation
  // ----------------------------------------------------------------------
  wire mclk_rise = mclk_s[1] & ~mclk_s[2];
  wire base_tick = clk_src ? pll_tick : mclk_rise;
  wire gen_bclk;
  wire gen_rise;
  wire gen_fall;

  audio_clock_gen u_clock_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .base_tick(base_tick),
    .sys_div_code(sys_div),
    .bclk_div_code(bclk_div),
    .run(master),
    .sys_tick_reg(sys_clk_tick),
    .bclk_reg(gen_bclk),
    .bclk_rise_reg(gen_rise),
    .bclk_fall_reg(gen_fall)
  );

  // ----------------------------------------------------------------------
  // bit clock events and frame level
  // ----------------------------------------------------------------------
  // slave edges are seen through the invert, so inversion swaps the edges
  wire s_eff = bclk_s[1] ^ bclk_inv;
  wire s_prev = bclk_s[2] ^ bclk_inv;
  wire rise_ev = master ? gen_rise : (s_eff & ~s_prev);
  wire fall_ev = master ? gen_fall : (~s_eff & s_prev);

  reg [5:0] mcnt_reg;
  wire [5:0] mcnt_next = mcnt_reg + 6'h01;
  // master frame: 32 bit clocks per phase, or a one-bit pulse in DSP
  wire m_level = dsp ? (mcnt_next == 6'h00) :
                 (mcnt_next[5] ? ~left_lvl : left_lvl);
  wire s_level = frame_s[1] ^ (fpol & ~dsp);
  wire fl = master ? m_level : s_level;

  // ----------------------------------------------------------------------
  // bit position tracking
  // ----------------------------------------------------------------------
  reg fl_prev_reg;
  reg [5:0] pos_reg;
  reg phase_reg;
  reg [6:0] len_reg;
  reg [31:0] cap_hold_reg;
  reg [31:0] rx_sh_reg;

  wire trans = dsp ? (fl & ~fl_prev_reg) : (fl != fl_prev_reg);
  wire [5:0] pos_sat = (pos_reg == 6'h3f) ? pos_reg : (pos_reg + 6'h01);
  wire [5:0] pos_n = trans ? 6'h00 : pos_sat;
  wire phase_n = dsp ? 1'b0 : (fl != left_lvl);
  wire [5:0] wl = word_bits(wl_code, fmt, byte_en);

  // MSB offset from the first bit clock after the frame edge
  reg [6:0] off;
  always @* begin
    case (fmt)
      `FMT_LEFT_JUSTIFIED: off = 7'd0;
      `FMT_I2S: off = 7'd1;
      `FMT_DSP: off = fpol ? 7'd0 : 7'd1;
      default: off = (len_reg > {1'b0, wl}) ? (len_reg - {1'b0, wl}) : 7'd0;
    endcase
  end

  wire [7:0] tx_slot = slot_of({1'b0, pos_n}, off, {1'b0, wl}, dsp, phase_n);
  wire [7:0] rx_slot = slot_of({1'b0, pos_reg}, off, {1'b0, wl}, dsp, phase_reg);
  wire [5:0] tx_idx = tx_slot[5:0];
  wire [5:0] rx_idx = rx_slot[5:0];
  wire [4:0] tx_bitsel = 5'd31 - tx_idx[4:0];
  wire [31:0] rx_word = {rx_sh_reg[30:0], din_s[1]};
  wire [5:0] rx_shift = 6'd32 - wl;
  wire rx_last = rx_slot[7] && (rx_slot[6] == play_swap) && (rx_idx == wl - 6'd1);

  // ----------------------------------------------------------------------
  // serial engine: launch on falling events, sample on rising events
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      mcnt_reg <= 6'h00;
      fl_prev_reg <= 1'b0;
      pos_reg <= 6'h3f;
      phase_reg <= 1'b0;
      len_reg <= 7'd64;
      cap_hold_reg <= 32'h0000_0000;
      rx_sh_reg <= 32'h0000_0000;
      capture_serial_out <= 1'b0;
      playback_word <= 32'h0000_0000;
      playback_strobe <= 1'b0;
    end else begin
      playback_strobe <= 1'b0;
      if (fall_ev) begin
        // the counter wraps at the frame, so no short last pulse can occur
        mcnt_reg <= mcnt_next;
        fl_prev_reg <= fl;
        pos_reg <= pos_n;
        phase_reg <= phase_n;
        if (trans) begin
          len_reg <= {1'b0, pos_reg} + 7'd1;
        end
        if (trans && (dsp || !phase_n)) begin
          cap_hold_reg <= capture_word;
        end
        if (tx_slot[7] && (mono_dup || tx_slot[6] == cap_swap)) begin
          capture_serial_out <= (trans && (dsp || !phase_n)) ?
                                capture_word[tx_bitsel] : cap_hold_reg[tx_bitsel];
        end else begin
          capture_serial_out <= 1'b0;
        end
      end
      if (rise_ev && rx_slot[7] && (rx_slot[6] == play_swap)) begin
        rx_sh_reg <= rx_word;
        if (rx_last) begin
          playback_word <= rx_word << rx_shift;
          playback_strobe <= 1'b1;
        end
      end
      if (!master) begin
        mcnt_reg <= 6'h3f;
      end
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  // registered so that clocks and data leave the block on the same edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      bclk_out <= 1'b0;
      frame_out <= 1'b0;
      bclk_oe_n <= 1'b1;
      frame_oe_n <= 1'b1;
    end else begin
      bclk_out <= gen_bclk ^ bclk_inv;
      if (gen_fall) begin
        frame_out <= m_level ^ (fpol & ~dsp);
      end
      bclk_oe_n <= ~master;
      frame_oe_n <= ~master;
    end
  end

  // ----------------------------------------------------------------------
  // filter coefficient select
  // ----------------------------------------------------------------------
  // coefficients assume a system clock of 256 samples; other clocks scale
  // the response, and software picks the nearest code for other rates
  always @(posedge aclk) begin
    if (!aresetn) begin
      filter_rate_sel <= 3'h0;
    end else if (rate_code > `SAMPLE_RATE_CODE_MAX) begin
      filter_rate_sel <= `SAMPLE_RATE_CODE_MAX;
    end else begin
      filter_rate_sel <= rate_code;
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------------
  wire [3:0] widx = s_axi_awaddr[5:2];
  wire wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  wire wr_hit = (widx == `IDX_SERIAL_PORT_FORMAT_CONTROL) ||
                (widx == `IDX_COMPANDER_WORD_CONTROL) ||
                (widx == `IDX_CLOCK_GENERATION_CONTROL) ||
                (widx == `IDX_ADDITIONAL_RATE_CONTROL);

  // both channels are taken together, one write at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_RESP_OKAY;
      fmt_ctl_reg <= `RST_SERIAL_PORT_FORMAT_CONTROL;
      cmp_ctl_reg <= `RST_COMPANDER_WORD_CONTROL;
      clk_ctl_reg <= `RST_CLOCK_GENERATION_CONTROL;
      rate_ctl_reg <= `RST_ADDITIONAL_RATE_CONTROL;
    end else begin
      s_axi_awready <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
      s_axi_wready <= !s_axi_awready && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        case (widx)
          `IDX_SERIAL_PORT_FORMAT_CONTROL:
            fmt_ctl_reg <= merge(fmt_ctl_reg, s_axi_wdata, s_axi_wstrb);
          `IDX_COMPANDER_WORD_CONTROL:
            cmp_ctl_reg <= merge(cmp_ctl_reg, s_axi_wdata, s_axi_wstrb);
          `IDX_CLOCK_GENERATION_CONTROL:
            clk_ctl_reg <= merge(clk_ctl_reg, s_axi_wdata, s_axi_wstrb);
          `IDX_ADDITIONAL_RATE_CONTROL:
            rate_ctl_reg <= merge(rate_ctl_reg, s_axi_wdata, s_axi_wstrb);
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------------
  wire [3:0] ridx = s_axi_araddr[5:2];
  reg [31:0] rd_val;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (ridx)
      `IDX_SERIAL_PORT_FORMAT_CONTROL: rd_val = {22'h00_0000, fmt_ctl_reg};
      `IDX_COMPANDER_WORD_CONTROL: rd_val = {22'h00_0000, cmp_ctl_reg};
      `IDX_CLOCK_GENERATION_CONTROL: rd_val = {22'h00_0000, clk_ctl_reg};
      `IDX_ADDITIONAL_RATE_CONTROL: rd_val = {22'h00_0000, rate_ctl_reg};
      `IDX_PORT_STATUS: rd_val = {24'h00_0000, master, phase_reg, pos_reg};
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
    end
  end

endmodule
`default_nettype wire

/* tb/audio_port_checker_assertions.sv */
// port assertions for the audio serial port control block
`timescale 1ns/100ps
`default_nettype none
module audio_port_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // pins and converter side
  input wire logic bclk_oe_n,
  input wire logic frame_oe_n,
  input wire logic playback_strobe,
  input wire logic [2:0] filter_rate_sel
);
  // ----------------------------------------------------------------
  // one clock domain, reset disables every check
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  write_accept_a: assert property (s_axi_awready |=> !s_axi_awready && s_axi_bvalid)
    else $error("write answer late or accept too long");
  write_pair_a: assert property (s_axi_awready == s_axi_wready)
    else $error("address and data accept split");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  read_answer_a: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved while waiting");
  rate_range_a: assert property (filter_rate_sel <= 3'h5)
    else $error("reserved rate code reached filters");
  clock_pins_a: assert property (bclk_oe_n == frame_oe_n)
    else $error("bit and frame clock roles differ");
  strobe_pulse_a: assert property (playback_strobe |=> !playback_strobe)
    else $error("playback strobe longer than one cycle");
endmodule
bind mono_codec_audio_port_ctrl audio_port_checker chk (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .bclk_oe_n, .frame_oe_n, .playback_strobe, .filter_rate_sel);
`default_nettype wire

/* tb/host_serial_model.sv */
// host serial port model: i2s sender of playback, receiver of capture
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
  // clocks from the device
  input wire logic bclk,
  input wire logic frame,
  // serial data
  input wire logic cap_in,
  output logic pb_out,
  // last left capture word, msb aligned
  output logic [31:0] cap_left
);
  localparam logic [31:0] PB_WORD = 32'hc3a5_5a3c;
  logic [5:0] pos = 6'h00;
  logic fr_d = 1'b0;
  logic [31:0] sh = 32'h0000_0000;
  initial pb_out = 1'b0;
  initial cap_left = 32'h0000_0000;
  // launch on falling edge; delay lets frame settle, both move together
  always @(negedge bclk) begin
    #1;
    if (frame != fr_d) pos = 6'h00;
    else pos = pos + 6'h01;
    fr_d = frame;
    if (pos >= 6'h01 && pos <= 6'h18) pb_out = PB_WORD[32 - pos];
    else pb_out = ~pb_out; // idle bits change so a stale value never passes
  end
  // capture on rising edge, msb one bit after the frame edge
  always @(posedge bclk) begin
    if (pos >= 6'h01 && pos <= 6'h18) sh = {sh[30:0], cap_in};
    if (pos == 6'h18 && !frame) cap_left = {sh[23:0], 8'h00};
  end
endmodule
`default_nettype wire

/* tb/mono_codec_audio_port_ctrl_tb_top.sv */
// self-checking testbench for the audio serial port control block
`timescale 1ns/100ps
`default_nettype none
module mono_codec_audio_port_ctrl_tb_top;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, mclk_pin = 0, pll_tick = 1, bclk_in = 0;
  logic frame_in = 0, playback_serial_in, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, bclk_out, bclk_oe_n, frame_out, frame_oe_n;
  logic capture_serial_out, playback_strobe, sys_clk_tick;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic [31:0] s_axi_wdata = 0, capture_word = 32'h9b3c_e1d4;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, playback_word, cap_left;
  logic [2:0] filter_rate_sel;
  int mismatches = 0, n_tests = 0, k, p0, p1, f0;
  mono_codec_audio_port_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mclk_pin, .pll_tick,
    .bclk_in, .bclk_out, .bclk_oe_n, .frame_in, .frame_out, .frame_oe_n, .playback_serial_in,
    .capture_serial_out, .capture_word, .playback_word, .playback_strobe, .sys_clk_tick,
    .filter_rate_sel);
  host_serial_model host (.bclk(bclk_out), .frame(frame_out), .cap_in(capture_serial_out),
    .pb_out(playback_serial_in), .cap_left);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a wait that ran out of its bound ends the run
  task automatic hang(input int i);
    if (i >= 9000) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (i = 0; i < 9000 && s_axi_awready !== 1; i++) @(posedge aclk);
    hang(i);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    @(posedge aclk); // a late bready lets the hold checks see a waiting answer
    s_axi_bready <= 1;
    @(posedge aclk);
    for (i = 0; i < 9000 && s_axi_bvalid !== 1; i++) @(posedge aclk);
    hang(i);
    chk(s_axi_bresp, er);
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (i = 0; i < 9000 && s_axi_arready !== 1; i++) @(posedge aclk);
    hang(i);
    s_axi_arvalid <= 0;
    @(posedge aclk); // a late rready lets the hold checks see a waiting answer
    s_axi_rready <= 1;
    @(posedge aclk);
    for (i = 0; i < 9000 && s_axi_rvalid !== 1; i++) @(posedge aclk);
    hang(i);
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, er);
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  // period between second and third rise, skips a settling period
  task automatic per(input logic f, output int n);
    int i, e;
    logic p, c;
    e = 0;
    n = 0;
    p = 1;
    for (i = 0; i < 9000 && e < 3; i++) begin
      @(posedge aclk);
      c = f ? frame_out : bclk_out;
      if (c && !p) e++;
      if (e == 2) n++;
      p = c;
    end
    hang(i);
  endtask
  // reformat, let 3000 bus clocks (just under three frames) pass, then compare both directions
  task automatic fmt_chk(input logic [31:0] f, input logic [31:0] cap, input logic [31:0] pb);
    wr(6'h10, f, 2'b00);
    repeat (3000) @(posedge aclk);
    chk(cap_left, cap);
    chk(playback_word, pb);
  endtask
  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial forever #4 aclk = ~aclk;
  // master clock pin at half the bus clock rate
  always @(posedge aclk) mclk_pin <= ~mclk_pin;
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(6'h10, 32'h0000_0050, 2'b00);
    rd(6'h14, 32'h0000_0000, 2'b00);
    rd(6'h18, 32'h0000_0140, 2'b00);
    rd(6'h1c, 32'h0000_0000, 2'b00);
    rd(6'h3c, 32'h0000_0000, 2'b10);
    wr(6'h3c, 32'h0000_0155, 2'b10);
    wr(6'h10, 32'hffff_ffff, 2'b00);
    rd(6'h10, 32'h0000_03ff, 2'b00);
    wr(6'h10, 32'h0000_0050, 2'b00);
    for (k = 0; k < 8; k++) begin
      wr(6'h1c, 32'(k << 1), 2'b00);
      chk(32'(filter_rate_sel), (k > 5) ? 5 : k);
    end
    wr(6'h1c, 32'h0000_0004, 2'b00);
    chk(32'(filter_rate_sel), 2);
    // master, divide by 8 keeps bit clock slow enough for sampling
    wr(6'h18, 32'h0000_01c1, 2'b00);
    chk(32'(bclk_oe_n), 0);
    per(0, p0);
    per(1, f0);
    chk(f0, 64 * p0);
    chk(p0, 16);
    repeat (3000) @(posedge aclk);
    chk(cap_left, {capture_word[31:8], 8'h00});
    chk(playback_word, 32'hc3a5_5a00);
    fmt_chk(32'h0000_0052, 32'h0, 32'hc3a5_5a00);
    fmt_chk(32'h0000_0252, {capture_word[31:8], 8'h00}, 32'hc3a5_5a00);
    fmt_chk(32'h0000_00d0, 32'h0, 32'hc3a5_5a00);
    fmt_chk(32'h0000_0010, {capture_word[31:16], 16'h0000}, 32'hc3a5_0000);
    wr(6'h14, 32'h0000_0020, 2'b00);
    fmt_chk(32'h0000_0050, {capture_word[31:24], 24'h00_0000}, 32'hc300_0000);
    wr(6'h18, 32'h0000_01c5, 2'b00);
    per(0, p1);
    chk(p1, 2 * p0);
    wr(6'h18, 32'h0000_01d9, 2'b00);
    per(0, p1);
    chk(p1, 32 * p0);
    wr(6'h18, 32'h0000_00c1, 2'b00);
    per(0, p1);
    chk(p1, 32);
    wr(6'h18, 32'h0000_0121, 2'b00);
    per(0, p1);
    chk(p1, 3);
    wr(6'h18, 32'h0000_0140, 2'b00);
    chk(32'(frame_oe_n), 1);
    summarize();
  end
endmodule
`default_nettype wire
